/* File: shared/dacrt_defs.svh */
/*
  constants for the trim and decode block: word fields, select codes,
  special-function codes, reset values and timing counts.
  assumes a 25 MHz core clock.
*/
`ifndef DACRT_DEFS_SVH
`define DACRT_DEFS_SVH
`define DACRT_SEL_INPUT 2'h3
`define DACRT_SEL_OFFSET 2'h2
`define DACRT_SEL_GAIN 2'h1
`define DACRT_SEL_FUNC 2'h0
`define DACRT_FN_IDLE 6'h00
`define DACRT_FN_CLRCODE 6'h01
`define DACRT_FN_SOFTCLR 6'h02
`define DACRT_FN_PDOWN 6'h08
`define DACRT_FN_PUP 6'h09
`define DACRT_FN_CTRL 6'h0C
`define DACRT_FN_MON 6'h0A
`define DACRT_FN_SOFTRST 6'h0F
`define DACRT_GAIN_RST 14'h3FFE
`define DACRT_OFFS_RST 14'h2000
`define DACRT_OFFS_MID 16'sh2000
`define DACRT_CODE_MAX 14'h3FFF
`define DACRT_MON_OFF 6'h3F
`define DACRT_CTRL_RST 14'h2000
`define DACRT_REF_SRC_POS 10
`define DACRT_REF_LVL_POS 12
`define DACRT_MON_EN_POS 9
`define DACRT_CLK_MHZ 25
`define DACRT_RESET_US 270
`define DACRT_SOFTCLR_US 35
`define DACRT_SOFTRST_US 135
`define DACRT_RESET_CYC (`DACRT_RESET_US * `DACRT_CLK_MHZ)
`define DACRT_SOFTCLR_CYC (`DACRT_SOFTCLR_US * `DACRT_CLK_MHZ)
`define DACRT_SOFTRST_CYC (`DACRT_SOFTRST_US * `DACRT_CLK_MHZ)
`endif

/* File: shared/dacrt_pkg.sv */
/*
  types for the trim and decode block.
  assumes dacrt_defs.svh for all numbers.
*/
package dacrt_pkg;
  typedef struct packed {
    logic [1:0] sel;
    logic [5:0] function_address;
    logic read_dir;
    logic [13:0] word_bits;
  } dacrt_word_s;
  typedef enum logic [1:0] {
    DACRT_IDLE,
    DACRT_BUSY
  } dacrt_state_e;
endpackage

/* File: rtl/dacrt_core.sv */
/*
  decode of incoming words into per-channel input, offset and gain,
  special-function handling and double-buffered trimmed codes.
  assumes one word per valid pulse from the front end, synchronous inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dacrt_defs.svh"
module dacrt_core
  import dacrt_pkg::*;
#(
  parameter int NCH = 40,
  parameter int RESET_CYC = `DACRT_RESET_CYC,
  parameter int SOFTCLR_CYC = `DACRT_SOFTCLR_CYC,
  parameter int SOFTRST_CYC = `DACRT_SOFTRST_CYC
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic dev_resetn_i,
  input wire logic word_valid_i,
  input wire dacrt_word_s word_i,
  input wire logic load_strobe_i,
  input wire logic [5:0] rd_chan_i,
  output logic busy_n_o,
  output logic [13:0] conv_code_o,
  output logic [13:0] ctrl_rd_o,
  output logic ref_source_bit_o,
  output logic ref_level_bit_o,
  output logic monitor_en_o,
  output logic [5:0] monitor_output_o,
  output logic powered_down_o
);
  typedef struct packed {
    dacrt_state_e st;
    logic [15:0] cnt;
    logic rst_d;
    logic [13:0] ctrl;
    logic [13:0] clr_code;
    logic [5:0] mon;
    logic pd;
    logic [13:0] rd;
  } dacrt_ctl_s;
  dacrt_ctl_s ctl_ff, nxt_ctl;
  logic [13:0] in_ff [NCH];
  logic [13:0] gain_ff [NCH];
  logic [13:0] offs_ff [NCH];
  logic [13:0] conv_ff [NCH];
  logic wr_ok, wr_chan, fill_all, do_clr, do_load;
  logic [5:0] ch;

  assign ch = word_i.function_address;
  assign wr_ok = word_valid_i && ctl_ff.st == DACRT_IDLE && !ctl_ff.pd;
  assign wr_chan = wr_ok && word_i.sel != `DACRT_SEL_FUNC && 32'(ch) < NCH;

  function automatic logic [13:0] trim(input logic [13:0] code, input logic [13:0] gain, input logic [13:0] offs);
    logic [28:0] prod;
    logic signed [17:0] sum;
    prod = 29'({15'h0000, code} * (15'(gain) + 15'h0002));
    sum = 18'($signed({3'h0, prod[28:14]})) + 18'($signed({4'h0, offs})) - 18'(`DACRT_OFFS_MID);
    if (sum < 18'sh00000) begin
      trim = 14'h0000;
    end else if (sum > 18'($signed({4'h0, `DACRT_CODE_MAX}))) begin
      trim = `DACRT_CODE_MAX;
    end else begin
      trim = sum[13:0];
    end
  endfunction

  always_comb begin
    nxt_ctl = ctl_ff;
    fill_all = 1'b0;
    do_clr = 1'b0;
    nxt_ctl.rst_d = dev_resetn_i;
    if (ctl_ff.st == DACRT_BUSY) begin
      nxt_ctl.cnt = ctl_ff.cnt - 16'h0001;
      if (ctl_ff.cnt == 16'h0001) begin
        nxt_ctl.st = DACRT_IDLE;
      end
    end
    if (ctl_ff.rst_d && !dev_resetn_i) begin
      fill_all = 1'b1;
      nxt_ctl.st = DACRT_BUSY;
      nxt_ctl.cnt = 16'(RESET_CYC);
      nxt_ctl.ctrl = `DACRT_CTRL_RST;
      nxt_ctl.clr_code = 14'h0000;
      nxt_ctl.mon = `DACRT_MON_OFF;
      nxt_ctl.pd = 1'b0;
    end else if (word_valid_i && ctl_ff.st == DACRT_IDLE && word_i.sel == `DACRT_SEL_FUNC) begin
      unique case (word_i.function_address)
        `DACRT_FN_PUP: begin
          nxt_ctl.pd = 1'b0;
        end
        `DACRT_FN_CTRL: begin
          if (word_i.read_dir) begin
            nxt_ctl.rd = ctl_ff.ctrl;
          end else if (!ctl_ff.pd) begin
            nxt_ctl.ctrl = word_i.word_bits;
          end
        end
        default: begin
          if (!ctl_ff.pd && !word_i.read_dir) begin
            unique case (word_i.function_address)
              `DACRT_FN_CLRCODE: nxt_ctl.clr_code = word_i.word_bits;
              `DACRT_FN_SOFTCLR: begin
                do_clr = 1'b1;
                nxt_ctl.st = DACRT_BUSY;
                nxt_ctl.cnt = 16'(SOFTCLR_CYC);
              end
              `DACRT_FN_PDOWN: nxt_ctl.pd = 1'b1;
              `DACRT_FN_MON: nxt_ctl.mon = word_i.word_bits[13:8];
              `DACRT_FN_SOFTRST: begin
                fill_all = 1'b1;
                nxt_ctl.st = DACRT_BUSY;
                nxt_ctl.cnt = 16'(SOFTRST_CYC);
                nxt_ctl.ctrl = `DACRT_CTRL_RST;
                nxt_ctl.mon = `DACRT_MON_OFF;
              end
              default: nxt_ctl.rd = ctl_ff.rd;
            endcase
          end
        end
      endcase
    end
    if (!resetn_i) begin
      fill_all = 1'b1;
      nxt_ctl.st = DACRT_IDLE;
      nxt_ctl.cnt = 16'h0000;
      nxt_ctl.rst_d = 1'b1;
      nxt_ctl.ctrl = `DACRT_CTRL_RST;
      nxt_ctl.clr_code = 14'h0000;
      nxt_ctl.mon = `DACRT_MON_OFF;
      nxt_ctl.pd = 1'b0;
      nxt_ctl.rd = 14'h0000;
      do_clr = 1'b0;
    end
  end

  assign do_load = load_strobe_i && ctl_ff.st == DACRT_IDLE && !fill_all;

  always_ff @(posedge core_clk_i) begin
    ctl_ff <= nxt_ctl;
    for (int i = 0; i < NCH; i++) begin
      if (fill_all) begin
        in_ff[i] <= 14'h0000;
        gain_ff[i] <= `DACRT_GAIN_RST;
        offs_ff[i] <= `DACRT_OFFS_RST;
        conv_ff[i] <= 14'h0000;
      end else begin
        if (do_clr) begin
          in_ff[i] <= ctl_ff.clr_code;
          conv_ff[i] <= ctl_ff.clr_code;
        end else if (do_load) begin
          conv_ff[i] <= trim(in_ff[i], gain_ff[i], offs_ff[i]);
        end
        if (wr_chan && 32'(ch) == i) begin
          unique case (word_i.sel)
            `DACRT_SEL_INPUT: in_ff[i] <= word_i.word_bits;
            `DACRT_SEL_OFFSET: offs_ff[i] <= word_i.word_bits;
            `DACRT_SEL_GAIN: gain_ff[i] <= {word_i.word_bits[13:1], 1'b0};
            default: in_ff[i] <= in_ff[i];
          endcase
        end
      end
    end
  end

  assign busy_n_o = ctl_ff.st == DACRT_IDLE;
  assign conv_code_o = 32'(rd_chan_i) < NCH ? conv_ff[rd_chan_i] : 14'h0000;
  assign ctrl_rd_o = ctl_ff.rd;
  assign ref_source_bit_o = ctl_ff.ctrl[`DACRT_REF_SRC_POS];
  assign ref_level_bit_o = ctl_ff.ctrl[`DACRT_REF_LVL_POS];
  assign monitor_en_o = ctl_ff.ctrl[`DACRT_MON_EN_POS];
  assign monitor_output_o = ctl_ff.mon;
  assign powered_down_o = ctl_ff.pd;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence rst_fall_s;
    $fell(dev_resetn_i) && ctl_ff.rst_d;
  endsequence
  rst_busy_a: assert property (rst_fall_s |=> !busy_n_o [*4]) else $error("busy not held after reset edge");
  rst_gain_a: assert property (rst_fall_s |=> gain_ff[0] == `DACRT_GAIN_RST) else $error("gain not restored");
  rst_offs_a: assert property (rst_fall_s |=> offs_ff[0] == `DACRT_OFFS_RST) else $error("offset not restored");
  gain_lsb_a: assert property (wr_chan && word_i.sel == `DACRT_SEL_GAIN && ch == 6'h00 |=> gain_ff[0][0] == 1'b0)
    else $error("gain lsb not zero");
  load_sync_a: assert property (do_load && !do_clr |=> conv_ff[0] == trim($past(in_ff[0]), $past(gain_ff[0]),
    $past(offs_ff[0]))) else $error("load did not transfer");
  in_write_a: assert property (wr_chan && word_i.sel == `DACRT_SEL_INPUT && ch == 6'h01 && !fill_all |=>
    in_ff[1] == $past(word_i.word_bits)) else $error("input code not written");
  hold_conv_a: assert property (!do_load && !do_clr && !fill_all |=> $stable(conv_ff[0])) else $error("code moved");
  mon_sel_a: assert property (wr_ok && word_i.sel == `DACRT_SEL_FUNC && ch == `DACRT_FN_MON && !word_i.read_dir &&
    !fill_all |=> monitor_output_o == $past(word_i.word_bits[13:8])) else $error("monitor not set");

  logic rst_edge;
  assign rst_edge = ctl_ff.rst_d && !dev_resetn_i;

  sequence fn_take_s(logic [5:0] code);
    word_valid_i && busy_n_o && !rst_edge && word_i.sel == `DACRT_SEL_FUNC && word_i.function_address == code;
  endsequence

  sequence fn_write_s(logic [5:0] code);
    fn_take_s(code) ##0 !word_i.read_dir && !powered_down_o;
  endsequence

  sequence chan_take_s(logic [1:0] code);
    word_valid_i && word_i.sel == code && ch == 6'h00 && !rst_edge;
  endsequence

  property softclr_p;
    fn_write_s(`DACRT_FN_SOFTCLR) |=>
      !busy_n_o && conv_ff[0] == $past(ctl_ff.clr_code) && in_ff[0] == $past(ctl_ff.clr_code);
  endproperty
  softclr_load_a: assert property (softclr_p)
    else $error("soft clear did not load clear code");

  property softrst_p;
    fn_write_s(`DACRT_FN_SOFTRST) |=>
      !busy_n_o && gain_ff[0] == `DACRT_GAIN_RST && offs_ff[0] == `DACRT_OFFS_RST &&
      monitor_output_o == `DACRT_MON_OFF;
  endproperty
  softrst_restore_a: assert property (softrst_p)
    else $error("soft reset did not restore");

  property pdown_p;
    fn_write_s(`DACRT_FN_PDOWN) |=> powered_down_o;
  endproperty
  pdown_set_a: assert property (pdown_p)
    else $error("power-down not entered");

  property pup_p;
    fn_take_s(`DACRT_FN_PUP) |=> !powered_down_o;
  endproperty
  pup_clear_a: assert property (pup_p)
    else $error("power-up not taken");

  property idle_cmd_p;
    fn_take_s(`DACRT_FN_IDLE) |=> busy_n_o && $stable(ctl_ff.ctrl) && $stable(powered_down_o);
  endproperty
  idle_cmd_a: assert property (idle_cmd_p)
    else $error("idle command changed state");

  property ctrl_wr_p;
    fn_write_s(`DACRT_FN_CTRL) |=>
      ref_source_bit_o == $past(word_i.word_bits[`DACRT_REF_SRC_POS]) &&
      ref_level_bit_o == $past(word_i.word_bits[`DACRT_REF_LVL_POS]);
  endproperty
  ctrl_ref_a: assert property (ctrl_wr_p)
    else $error("reference bits not written");

  property ctrl_rd_p;
    fn_take_s(`DACRT_FN_CTRL) ##0 word_i.read_dir |=> ctrl_rd_o == $past(ctl_ff.ctrl);
  endproperty
  ctrl_read_a: assert property (ctrl_rd_p)
    else $error("control read wrong");

  property offs_wr_p;
    chan_take_s(`DACRT_SEL_OFFSET) ##0 wr_chan |=> offs_ff[0] == $past(word_i.word_bits);
  endproperty
  offs_write_a: assert property (offs_wr_p)
    else $error("offset not written");

  property gain_wr_p;
    chan_take_s(`DACRT_SEL_GAIN) ##0 wr_chan |=> gain_ff[0] == {$past(word_i.word_bits[13:1]), 1'b0};
  endproperty
  gain_write_a: assert property (gain_wr_p)
    else $error("gain not written");

  property busy_drop_p;
    !busy_n_o ##0 chan_take_s(`DACRT_SEL_INPUT) |=> $stable(in_ff[0]);
  endproperty
  busy_drop_a: assert property (busy_drop_p)
    else $error("word taken while busy");

  property pd_drop_p;
    powered_down_o ##0 chan_take_s(`DACRT_SEL_INPUT) |=> $stable(in_ff[0]);
  endproperty
  pd_drop_a: assert property (pd_drop_p)
    else $error("word taken in power-down");

  property busy_load_p;
    !busy_n_o && load_strobe_i && !rst_edge |=> $stable(conv_ff[0]);
  endproperty
  busy_load_a: assert property (busy_load_p)
    else $error("load taken while busy");

  property rst_all_p;
    rst_fall_s |=> in_ff[0] == 14'h0000 && conv_ff[0] == 14'h0000 && monitor_output_o == `DACRT_MON_OFF;
  endproperty
  rst_codes_a: assert property (rst_all_p)
    else $error("codes not restored");

  property rst_ctrl_p;
    rst_fall_s |=> !powered_down_o && !monitor_en_o;
  endproperty
  rst_ctrl_a: assert property (rst_ctrl_p)
    else $error("control not restored");

  property busy_cnt_p;
    !busy_n_o |-> ctl_ff.cnt != 16'h0000;
  endproperty
  busy_cnt_a: assert property (busy_cnt_p)
    else $error("busy without count");

  property last_chan_p;
    wr_chan && word_i.sel == `DACRT_SEL_INPUT && 32'(ch) == NCH - 1 && !fill_all |=>
      in_ff[NCH - 1] == $past(word_i.word_bits);
  endproperty
  last_chan_a: assert property (last_chan_p)
    else $error("last channel not written");

  property last_load_p;
    do_load && !do_clr |=>
      conv_ff[NCH - 1] == trim($past(in_ff[NCH - 1]), $past(gain_ff[NCH - 1]), $past(offs_ff[NCH - 1]));
  endproperty
  last_load_a: assert property (last_load_p)
    else $error("last channel not loaded");
endmodule
`default_nettype wire

/* File: verification/dacrt_host_model.sv */
/*
  host model: sends one decoded word per pulse and load strobes.
  assumes the core clock comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module dacrt_host_model
  import dacrt_pkg::*;
(
  input wire logic core_clk_i,
  output logic word_valid_o,
  output dacrt_word_s word_o,
  output logic load_strobe_o
);
  initial begin
    word_valid_o = 1'b0;
    word_o = '0;
    load_strobe_o = 1'b0;
  end
  // select bits steer the word; fields scrambled when idle
  task automatic send(input logic [1:0] sel, input logic [5:0] fa, input logic rdir, input logic [13:0] d);
    @(posedge core_clk_i);
    word_valid_o <= 1'b1;
    word_o <= '{sel, fa, rdir, d};
    @(posedge core_clk_i);
    word_valid_o <= 1'b0;
    word_o <= ~word_o;
  endtask
  task automatic load();
    @(posedge core_clk_i);
    load_strobe_o <= 1'b1;
    @(posedge core_clk_i);
    load_strobe_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_dacrt_core.sv */
/*
  self-checking bench for dacrt_core.
  assumes busy counts shortened to 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dacrt_defs.svh"
module tb_dacrt_core;
  import dacrt_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, drst_n = 1'b1;
  logic [5:0] rd_chan = 6'h00;
  logic vld, ld, busy_n, rsrc, rlvl, mon_en, pd;
  dacrt_word_s w;
  logic [13:0] conv, ctrl;
  logic [5:0] mon;
  int n_fail = 0, checks_done = 0;
  always #20 clk = ~clk;
  dacrt_host_model u_dacrt_host_model(.core_clk_i(clk), .word_valid_o(vld), .word_o(w), .load_strobe_o(ld));
  dacrt_core #(.RESET_CYC(4), .SOFTCLR_CYC(4), .SOFTRST_CYC(4)) u_dacrt_core(.core_clk_i(clk), .resetn_i(rstn),
    .dev_resetn_i(drst_n), .word_valid_i(vld), .word_i(w), .load_strobe_i(ld), .rd_chan_i(rd_chan),
    .busy_n_o(busy_n), .conv_code_o(conv), .ctrl_rd_o(ctrl), .ref_source_bit_o(rsrc), .ref_level_bit_o(rlvl),
    .monitor_en_o(mon_en), .monitor_output_o(mon), .powered_down_o(pd));
  task automatic chk(input string nm, input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic logic [13:0] trim(int x, int g, int o);
    int v;
    v = (((g + 2) * x) >>> 14) + o - 8192;
    return (v < 0) ? 14'h0000 : (v > 16383) ? 14'h3FFF : v[13:0];
  endfunction
  task automatic wr(input logic [1:0] s, input logic [5:0] a, input logic r, input logic [13:0] d);
    u_dacrt_host_model.send(s, a, r, d);
    #1;
  endtask
  task automatic rd(input logic [5:0] ch, input logic [13:0] exp, input string nm);
    @(posedge clk);
    rd_chan <= ch;
    @(posedge clk);
    #1;
    chk(nm, conv, exp);
  endtask
  task automatic wait_busy();
    int i;
    #1;
    for (i = 0; i < 20 && busy_n !== 1'b0; i++) @(posedge clk) #1;
    chk("busy_low", busy_n, 1'b0);
    for (i = 0; i < 50 && busy_n !== 1'b1; i++) @(posedge clk) #1;
    chk("busy_high", busy_n, 1'b1);
  endtask
  task automatic t_reset();
    chk("busy_n", busy_n, 1'b1);
    chk("mon_rst", mon, 14'h003F);
    wr(`DACRT_SEL_INPUT, 6'h03, 1'b0, 14'h2000);
    u_dacrt_host_model.load();
    rd(6'h03, 14'h2000, "defaults");
  endtask
  task automatic t_trim();
    logic [13:0] g[5] = '{14'h3FFE, 14'h2FFE, 14'h1FFE, 14'h0FFE, 14'h0000};
    logic [13:0] x[4] = '{14'h2000, 14'h2000, 14'h3FFF, 14'h0000};
    logic [13:0] o[4] = '{14'h3FFF, 14'h0000, 14'h3FFF, 14'h0000};
    for (int i = 0; i < 5; i++) begin
      wr(`DACRT_SEL_GAIN, 6'h07, 1'b0, g[i]);
      wr(`DACRT_SEL_INPUT, 6'h07, 1'b0, 14'h3FFF);
      u_dacrt_host_model.load();
      rd(6'h07, trim(16383, g[i], 8192), "gain");
    end
    for (int i = 0; i < 4; i++) begin
      wr(`DACRT_SEL_OFFSET, 6'h08, 1'b0, o[i]);
      wr(`DACRT_SEL_INPUT, 6'h08, 1'b0, x[i]);
      u_dacrt_host_model.load();
      rd(6'h08, trim(x[i], 16382, o[i]), "offset");
    end
  endtask
  task automatic t_dbuf();
    wr(`DACRT_SEL_INPUT, 6'h09, 1'b0, 14'h1234);
    wr(`DACRT_SEL_GAIN, 6'h27, 1'b0, 14'h1FFE);
    wr(`DACRT_SEL_INPUT, 6'h27, 1'b0, 14'h3FFF);
    rd(6'h09, 14'h0000, "no_load");
    u_dacrt_host_model.load();
    rd(6'h09, 14'h1234, "loaded");
    rd(6'h27, trim(16383, 8190, 8192), "chan39");
  endtask
  task automatic t_sfr();
    wr(`DACRT_SEL_FUNC, `DACRT_FN_IDLE, 1'b0, 14'h0000);
    chk("idle", busy_n, 1'b1);
    wr(`DACRT_SEL_FUNC, `DACRT_FN_CTRL, 1'b0, 14'h1600);
    chk("ref", {rlvl, rsrc, mon_en}, 14'h0007);
    wr(`DACRT_SEL_FUNC, `DACRT_FN_CTRL, 1'b1, 14'h0000);
    chk("ctrl_rd", ctrl, 14'h1600);
    wr(`DACRT_SEL_FUNC, `DACRT_FN_MON, 1'b0, 14'h0500);
    chk("mon", mon, 14'h0005);
    wr(`DACRT_SEL_FUNC, `DACRT_FN_PDOWN, 1'b0, 14'h0000);
    chk("pd", pd, 14'h0001);
    wr(`DACRT_SEL_INPUT, 6'h0A, 1'b0, 14'h3FFF);
    wr(`DACRT_SEL_FUNC, `DACRT_FN_PUP, 1'b0, 14'h0000);
    chk("pu", pd, 14'h0000);
    u_dacrt_host_model.load();
    rd(6'h0A, 14'h0000, "pd_drop");
    wr(`DACRT_SEL_FUNC, `DACRT_FN_CLRCODE, 1'b0, 14'h0123);
    u_dacrt_host_model.send(`DACRT_SEL_FUNC, `DACRT_FN_SOFTCLR, 1'b0, 14'h0000);
    wait_busy();
    rd(6'h0A, 14'h0123, "softclr");
    u_dacrt_host_model.send(`DACRT_SEL_FUNC, `DACRT_FN_SOFTRST, 1'b0, 14'h0000);
    wait_busy();
    rd(6'h0A, 14'h0000, "softrst");
    chk("mon_off", mon, 14'h003F);
  endtask
  task automatic t_devrst();
    @(posedge clk) drst_n <= 1'b0;
    wr(`DACRT_SEL_INPUT, 6'h09, 1'b0, 14'h3FFF);
    u_dacrt_host_model.load();
    wait_busy();
    drst_n <= 1'b1;
    rd(6'h09, 14'h0000, "devrst");
    u_dacrt_host_model.load();
    rd(6'h09, 14'h0000, "busy_drop");
  endtask
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_trim();
    t_dbuf();
    t_sfr();
    t_dbuf();
    t_devrst();
    finish_test();
  end
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
